// File: csb_pkg.sv
package csb_pkg;

    // -----------------------------------------------------------------
    // Register map (word aligned byte addresses)
    // -----------------------------------------------------------------
    localparam logic [11:0] OFF_PC        = 12'h000;
    localparam logic [11:0] OFF_PSW       = 12'h004;
    localparam logic [11:0] OFF_VTB       = 12'h008;
    localparam logic [11:0] OFF_RLINK     = 12'h00C;
    localparam logic [11:0] OFF_SSP       = 12'h010;
    localparam logic [11:0] OFF_USP       = 12'h014;
    localparam logic [11:0] OFF_MDH       = 12'h018;
    localparam logic [11:0] OFF_MDL       = 12'h01C;
    localparam logic [11:0] OFF_BOOT      = 12'h020;
    localparam logic [11:0] OFF_DECODE    = 12'h024;
    localparam logic [11:0] OFF_DECRES    = 12'h028;
    localparam logic [11:0] OFF_INTREQ    = 12'h02C;
    localparam logic [11:0] OFF_INTRES    = 12'h030;
    localparam logic [11:0] OFF_FLAGS     = 12'h034;
    localparam logic [11:0] OFF_GPR       = 12'h040;
    localparam logic [11:0] OFF_GPR_END   = 12'h07C;

    // -----------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------
    localparam logic [31:0] RST_VTB       = 32'h000F_FC00;
    localparam logic [31:0] RST_SSP       = 32'h0000_0000;
    localparam logic [31:0] RST_UNDEF     = 32'h0000_0000;
    localparam logic [4:0]  RST_ILM       = 5'h0F;
    localparam logic [1:0]  RST_BUSMODE   = 2'h2;

    // -----------------------------------------------------------------
    // Status word field layout
    // -----------------------------------------------------------------
    localparam int PSW_C   = 0;
    localparam int PSW_V   = 1;
    localparam int PSW_Z   = 2;
    localparam int PSW_N   = 3;
    localparam int PSW_I   = 4;
    localparam int PSW_S   = 5;
    localparam int PSW_T   = 8;
    localparam int PSW_ILM = 16;
    localparam logic [31:0] PSW_WMASK = 32'h001F_013F;

    // -----------------------------------------------------------------
    // Address map
    // -----------------------------------------------------------------
    localparam logic [31:0] MAP_IO_BASE   = 32'h0000_0400;
    localparam logic [31:0] MAP_IO_END    = 32'h0000_0800;
    localparam logic [31:0] MAP_RAM_BASE  = 32'h0000_1000;
    localparam logic [31:0] MAP_RAM_END   = 32'h0000_1800;
    localparam logic [31:0] MAP_EXT_BASE  = 32'h0001_0000;
    localparam logic [9:0]  DIR_BYTE_MAX  = 10'h0FF;
    localparam logic [9:0]  DIR_HALF_MAX  = 10'h1FF;
    localparam logic [9:0]  DIR_WORD_MAX  = 10'h3FF;

    typedef enum logic [2:0] {
        CSB_REG_EXTROM  = 3'h0,
        CSB_REG_IO      = 3'h1,
        CSB_REG_RAM     = 3'h2,
        CSB_REG_EXTAREA = 3'h3,
        CSB_REG_INHIB   = 3'h4
    } csb_region_e;

    typedef enum logic [1:0] {
        CSB_W_BYTE = 2'h0,
        CSB_W_HALF = 2'h1,
        CSB_W_WORD = 2'h2
    } csb_width_e;

    // Boot select pin codes and bus mode codes.
    localparam logic [2:0] BOOT_EXT8  = 3'h0;
    localparam logic [2:0] BOOT_EXT16 = 3'h1;
    localparam logic [2:0] BOOT_INT   = 3'h3;
    localparam logic [1:0] BUS_SINGLE = 2'h0;
    localparam logic [1:0] BUS_INTROM = 2'h1;
    localparam logic [1:0] BUS_EXTROM = 2'h2;

endpackage : csb_pkg

// File: csb_dec_if.sv
`timescale 1ns/1ps
interface csb_dec_if;
    logic [31:0]              addr;
    csb_pkg::csb_width_e      width;
    csb_pkg::csb_region_e     region;
    logic                     direct_ok;

    modport user
    (
        output addr,
        output width,
        input  region,
        input  direct_ok
    );
    modport dec
    (
        input  addr,
        input  width,
        output region,
        output direct_ok
    );
endinterface : csb_dec_if

// File: csb_addr_decode.sv
`timescale 1ns/1ps
module csb_addr_decode
(
    csb_dec_if.dec d
);

    // -----------------------------------------------------------------
    // Region decode over the flat 32-bit space
    // -----------------------------------------------------------------
    // The whole 32-bit space is decoded with no bank or segment state.
    always_comb
    begin
        if (d.addr < csb_pkg::MAP_IO_BASE)
            d.region = csb_pkg::CSB_REG_EXTROM;
        else if (d.addr < csb_pkg::MAP_IO_END)
            d.region = csb_pkg::CSB_REG_IO;
        else if (d.addr >= csb_pkg::MAP_RAM_BASE &&
                 d.addr < csb_pkg::MAP_RAM_END)
            d.region = csb_pkg::CSB_REG_RAM;
        else if (d.addr >= csb_pkg::MAP_EXT_BASE)
            d.region = csb_pkg::CSB_REG_EXTAREA;
        else
            d.region = csb_pkg::CSB_REG_INHIB;
    end

    // -----------------------------------------------------------------
    // Direct operand window, sized by access width
    // -----------------------------------------------------------------
    always_comb
    begin
        case (d.width)
            csb_pkg::CSB_W_BYTE:
                d.direct_ok = d.addr <= {22'h0, csb_pkg::DIR_BYTE_MAX};
            csb_pkg::CSB_W_HALF:
                d.direct_ok = d.addr <= {22'h0, csb_pkg::DIR_HALF_MAX};
            csb_pkg::CSB_W_WORD:
                d.direct_ok = d.addr <= {22'h0, csb_pkg::DIR_WORD_MAX};
            default:
                d.direct_ok = 1'b0;
        endcase
    end

endmodule : csb_addr_decode

// File: csb_cpu_state.sv
`timescale 1ns/1ps
// What this block does
// - Decodes a flat 4 Gbyte, 32-bit byte address space with no banking.
// - Maps I/O from 400H, RAM 1000H-17FFH, inhibited gaps, external 10000H up.
// - Direct window limits: byte 0FFH, halfword 1FFH, word 3FFH.
// - Vector table base resets to 000FFC00H.
// - System stack pointer resets to zero; others left indeterminate.
// - Return link register holds the subroutine return address.
// - Multiply/divide high and low result words are 32 bits each.
// - Status word holds condition flags, system flags and level mask.
// - Stack-select flag picks system or user stack pointer as R15.
// - Interrupt enable flag gates user interrupt acceptance.
// - Negative, zero, overflow and carry arithmetic flags are kept.
// - Trace flag enables the single-step trace trap.
// - Five-bit level mask; request accepted only if higher priority.
// - Level 0 is highest, 31 lowest; 01111 is level 15.
// - Sixteen 32-bit registers; R13 accumulator, R14 frame, R15 stack.
// - R0-R14 undefined at reset; R15 reads the zero system stack pointer.
// - Boot pins 000 ext 8-bit, 001 ext 16-bit, 011 internal, else inhibit.
module csb_cpu_state
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        boot_select_pin2,
    input  wire logic        boot_select_pin1,
    input  wire logic        boot_select_pin0,
    output logic             trace_trap_en,
    output logic             boot_inhibited
);

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [31:0]        pc;
        logic [31:0]        psw;
        logic [31:0]        vtb;
        logic [31:0]        rlink;
        logic [31:0]        system_stack_pointer;
        logic [31:0]        user_stack_pointer;
        logic [31:0]        muldiv_result_high;
        logic [31:0]        muldiv_result_low;
        logic [14:0][31:0]  gpr;
        logic [1:0]         bus_mode;
        logic               bus_wide;
        logic [2:0]         boot_pins;
        logic               strap_taken;
        logic               boot_inh;
        logic [31:0]        dec_addr;
        logic [1:0]         dec_width;
        logic [4:0]         int_level;
        logic               int_req;
        logic               int_user;
        logic               int_accept;
        logic               trace_en;
        logic [31:0]        rdata;
        logic               ready;
        logic               err;
    } csb_state_s;

    csb_state_s r;
    csb_state_s next_r;

    csb_dec_if dec_bus ();

    csb_addr_decode u_dec
    (
        .d (dec_bus.dec)
    );

    assign dec_bus.addr  = r.dec_addr;
    assign dec_bus.width = csb_pkg::csb_width_e'(r.dec_width);

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    // A lower level number is a higher priority, so acceptance is "less".
    function automatic logic level_beats(input logic [4:0] req,
                                         input logic [4:0] mask);
        level_beats = req < mask;
    endfunction : level_beats

    function automatic logic boot_bad(input logic [2:0] pins);
        boot_bad = !(pins == csb_pkg::BOOT_EXT8 ||
                     pins == csb_pkg::BOOT_EXT16 ||
                     pins == csb_pkg::BOOT_INT);
    endfunction : boot_bad

    logic        apb_wr;
    logic        apb_rd;
    logic [31:0] r15_view;
    logic [3:0]  gidx;

    assign apb_wr   = psel && penable && pwrite && !r.ready;
    assign apb_rd   = psel && penable && !pwrite && !r.ready;
    // R15 is not stored: it is a view of whichever stack pointer is live.
    assign r15_view = r.psw[csb_pkg::PSW_S] ? r.user_stack_pointer : r.system_stack_pointer;
    assign gidx     = paddr[5:2];

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb
    begin
        next_r       = r;
        next_r.ready = 1'b0;
        next_r.err   = 1'b0;
        next_r.rdata = 32'h0000_0000;

        // Straps are caught once on the first clock after reset release.
        if (!r.strap_taken)
        begin
            next_r.strap_taken = 1'b1;
            next_r.boot_pins   = {boot_select_pin2, boot_select_pin1,
                                  boot_select_pin0};
            next_r.boot_inh    = boot_bad({boot_select_pin2,
                                  boot_select_pin1, boot_select_pin0});
            // External vector modes fix the width; internal uses register.
            next_r.bus_wide    = (boot_select_pin0 && !boot_select_pin1);
        end

        // Accept a request only with a stronger level than the mask
        // and, for a user request, with interrupts enabled.
        next_r.int_accept = r.int_req &&
            (!r.int_user || r.psw[csb_pkg::PSW_I]) &&
            level_beats(r.int_level,
                        r.psw[csb_pkg::PSW_ILM +: 5]);
        next_r.trace_en = r.psw[csb_pkg::PSW_T];

        if (apb_wr)
        begin
            next_r.ready = 1'b1;
            case (paddr)
                csb_pkg::OFF_PC:     next_r.pc    = pwdata;
                csb_pkg::OFF_PSW:    next_r.psw   = pwdata &
                                         csb_pkg::PSW_WMASK;
                csb_pkg::OFF_VTB:    next_r.vtb   = pwdata;
                csb_pkg::OFF_RLINK:  next_r.rlink = pwdata;
                csb_pkg::OFF_SSP:    next_r.system_stack_pointer   = pwdata;
                csb_pkg::OFF_USP:    next_r.user_stack_pointer   = pwdata;
                csb_pkg::OFF_MDH:    next_r.muldiv_result_high   = pwdata;
                csb_pkg::OFF_MDL:    next_r.muldiv_result_low   = pwdata;
                csb_pkg::OFF_BOOT:
                begin
                    // Only external ROM mode is legal; others are refused.
                    if (pwdata[1:0] == csb_pkg::BUS_EXTROM)
                    begin
                        next_r.bus_mode = pwdata[1:0];
                        if (r.boot_pins == csb_pkg::BOOT_INT)
                            next_r.bus_wide = pwdata[2];
                    end
                    else
                        next_r.err = 1'b1;
                end
                csb_pkg::OFF_DECODE:
                    next_r.dec_addr = pwdata;
                csb_pkg::OFF_DECRES:
                    next_r.dec_width = pwdata[1:0];
                csb_pkg::OFF_INTREQ:
                begin
                    next_r.int_level = pwdata[4:0];
                    next_r.int_user  = pwdata[8];
                    next_r.int_req   = pwdata[9];
                end
                default:
                begin
                    if (paddr >= csb_pkg::OFF_GPR &&
                        paddr <= csb_pkg::OFF_GPR_END &&
                        paddr[1:0] == 2'h0)
                    begin
                        if (gidx == 4'hF)
                        begin
                            if (r.psw[csb_pkg::PSW_S])
                                next_r.user_stack_pointer = pwdata;
                            else
                                next_r.system_stack_pointer = pwdata;
                        end
                        else
                            next_r.gpr[gidx] = pwdata;
                    end
                    else
                        next_r.err = 1'b1;
                end
            endcase
        end
        else if (apb_rd)
        begin
            next_r.ready = 1'b1;
            case (paddr)
                csb_pkg::OFF_PC:     next_r.rdata = r.pc;
                csb_pkg::OFF_PSW:    next_r.rdata = r.psw;
                csb_pkg::OFF_VTB:    next_r.rdata = r.vtb;
                csb_pkg::OFF_RLINK:  next_r.rdata = r.rlink;
                csb_pkg::OFF_SSP:    next_r.rdata = r.system_stack_pointer;
                csb_pkg::OFF_USP:    next_r.rdata = r.user_stack_pointer;
                csb_pkg::OFF_MDH:    next_r.rdata = r.muldiv_result_high;
                csb_pkg::OFF_MDL:    next_r.rdata = r.muldiv_result_low;
                csb_pkg::OFF_BOOT:
                    next_r.rdata = {24'h0, r.boot_pins, r.boot_inh,
                                    1'b0, r.bus_wide, r.bus_mode};
                csb_pkg::OFF_DECODE: next_r.rdata = r.dec_addr;
                csb_pkg::OFF_DECRES:
                    next_r.rdata = {23'h0, dec_bus.direct_ok,
                                    1'b0, dec_bus.region,
                                    2'h0, r.dec_width};
                csb_pkg::OFF_INTREQ:
                    next_r.rdata = {22'h0, r.int_req, r.int_user,
                                    3'h0, r.int_level};
                csb_pkg::OFF_INTRES:
                    next_r.rdata = {31'h0, r.int_accept};
                csb_pkg::OFF_FLAGS:
                    next_r.rdata = {31'h0, r.trace_en};
                default:
                begin
                    if (paddr >= csb_pkg::OFF_GPR &&
                        paddr <= csb_pkg::OFF_GPR_END &&
                        paddr[1:0] == 2'h0)
                        next_r.rdata = (gidx == 4'hF) ? r15_view
                                       : r.gpr[gidx];
                    else
                        next_r.err = 1'b1;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    // Indeterminate registers still get a constant so simulation is
    // deterministic; software must not rely on that value.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r          <= '0;
            r.vtb      <= csb_pkg::RST_VTB;
            r.system_stack_pointer      <= csb_pkg::RST_SSP;
            r.pc       <= csb_pkg::RST_UNDEF;
            r.psw      <= {11'h0, csb_pkg::RST_ILM, 16'h0};
            r.bus_mode <= csb_pkg::RST_BUSMODE;
        end
        else
            r <= next_r;
    end

    assign prdata         = r.rdata;
    assign pready         = r.ready;
    assign pslverr        = r.err;
    assign trace_trap_en  = r.trace_en;
    assign boot_inhibited = r.boot_inh;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    sequence wr_to(logic [11:0] a);
        psel && penable && pwrite && !pready && paddr == a;
    endsequence

    vtb_reset_val_a: assert property (@(posedge pclk)
        $rose(presetn) |-> r.vtb == 32'h000F_FC00)
        else $error("vector table base reset value wrong");

    ssp_reset_zero_a: assert property (@(posedge pclk)
        $rose(presetn) |-> r.system_stack_pointer == 32'h0)
        else $error("system stack pointer not zero after reset");

    r15_select_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        r15_view == (r.psw[5] ? r.user_stack_pointer : r.system_stack_pointer))
        else $error("R15 view follows wrong stack pointer");

    int_gate_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (!r.psw[4] && r.int_user) |=> !r.int_accept)
        else $error("interrupt accepted while disabled");

    level_mask_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (r.int_req && r.psw[4] && r.int_user &&
         r.int_level >= r.psw[20:16]) |=> !r.int_accept)
        else $error("interrupt accepted at masked level");

    trace_follow_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        ##1 trace_trap_en == $past(r.psw[8]))
        else $error("trace enable does not follow flag");

    busmode_only_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        r.bus_mode == 2'h2)
        else $error("illegal bus mode stored");

    mdl_write_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr_to(12'h01C) |=> ##1 r.muldiv_result_low == $past(pwdata, 2))
        else $error("result low word not written");

    ram_decode_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (r.dec_addr >= 32'h1000 && r.dec_addr < 32'h1800)
        |-> dec_bus.region == csb_pkg::CSB_REG_RAM)
        else $error("RAM region not decoded");

    boot_code_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        r.strap_taken |-> r.boot_inh == (r.boot_pins == 3'h2 ||
                                         r.boot_pins[2]))
        else $error("boot pin decode wrong");

endmodule : csb_cpu_state

// File: cpu_state_and_boot_mode_tb_top.sv
`timescale 1ns/1ps
module cpu_state_and_boot_mode_tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  pins;
    logic        trace_trap_en;
    logic        boot_inhibited;
    logic [31:0] rd;
    logic        er;
    logic [31:0] v;
    logic [31:0] a;
    logic [4:0]  interrupt_level_mask;
    logic [4:0]  lvl;
    logic [11:0] regs [7];
    logic [31:0] adrs [14];
    integer      seed;
    int          failures;
    int          checks;
    int          cycles;

    csb_cpu_state csb_cpu_state_i
    (
        .pclk             (pclk),
        .presetn          (presetn),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .boot_select_pin2 (pins[2]),
        .boot_select_pin1 (pins[1]),
        .boot_select_pin0 (pins[0]),
        .trace_trap_en    (trace_trap_en),
        .boot_inhibited   (boot_inhibited)
    );

    always #2 pclk = ~pclk;

    // ------------------------------------------------------------------
    // Reporting and bus tasks
    // ------------------------------------------------------------------
    task automatic final_report;
        if (failures == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            failures = failures + 1;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // The request stands until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only pready or the bench's cycle ceiling ends this wait.
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rdc(input logic [11:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        chk(rd, exp);
    endtask : rdc

    task automatic do_reset(input logic [2:0] p);
        presetn <= 1'b0;
        pins    <= p;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask : do_reset

    function automatic logic [31:0] dec_exp(input logic [31:0] ad,
                                            input logic [1:0] w);
        logic [2:0] r;
        logic [9:0] m;
        r = 3'h3;
        if (ad < 32'h10000)
            r = 3'h4;
        if (ad < 32'h1800)
            r = 3'h2;
        if (ad < 32'h1000)
            r = 3'h4;
        if (ad < 32'h800)
            r = 3'h1;
        if (ad < 32'h400)
            r = 3'h0;
        m = (w == 2'h0) ? 10'h0FF : (w == 2'h1) ? 10'h1FF : 10'h3FF;
        return {23'h0, ad <= {22'h0, m}, 1'b0, r, 4'h0};
    endfunction : dec_exp

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        pclk     = 1'b0;
        presetn  = 1'b0;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 12'h000;
        pwdata   = 32'h0;
        pins     = 3'h0;
        seed     = 32'hcfaf1686;
        failures = 0;
        checks   = 0;
        cycles   = 0;
        regs = '{12'h000, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018,
                 12'h01C};
        adrs = '{32'h0, 32'hFC, 32'h100, 32'h1FC, 32'h200, 32'h3FC,
                 32'h400, 32'h7FC, 32'h800, 32'hFFC, 32'h1000, 32'h17FC,
                 32'hFFFC, 32'h10000};
        do_reset(3'h0);
        rdc(12'h008, 32'h000F_FC00);
        rdc(12'h010, 32'h0);
        rdc(12'h07C, 32'h0);
        rdc(12'h004, 32'h000F_0000);
        for (int i = 0; i < 7; i++)
        begin
            v = $random(seed);
            apb(1'b1, regs[i], v);
            rdc(regs[i], v);
        end
        for (int i = 0; i < 15; i++)
        begin
            v = $random(seed);
            apb(1'b1, 12'h040 + 12'(4 * i), v);
            rdc(12'h040 + 12'(4 * i), v);
        end
        for (int i = 0; i < 6; i++)
        begin
            v = (i < 2) ? {32{i[0]}} : $random(seed);
            apb(1'b1, 12'h004, v);
            rdc(12'h004, v & 32'h001F_013F);
            chk({31'h0, trace_trap_en}, {31'h0, v[8]});
            rdc(12'h034, {31'h0, v[8]});
        end
        apb(1'b1, 12'h010, 32'h1111_0000);
        apb(1'b1, 12'h014, 32'h2222_0000);
        apb(1'b1, 12'h004, 32'h0);
        rdc(12'h07C, 32'h1111_0000);
        apb(1'b1, 12'h004, 32'h20);
        rdc(12'h07C, 32'h2222_0000);
        // Equal and adjacent levels sit at the acceptance boundary.
        for (int i = 0; i < 32; i++)
        begin
            v = $random(seed);
            interrupt_level_mask = v[4:0];
            lvl = (i < 8) ? interrupt_level_mask - 5'(i[0]) : v[12:8];
            apb(1'b1, 12'h004, {11'h0, interrupt_level_mask, 11'h0, v[16], 4'h0});
            apb(1'b1, 12'h02C, {22'h0, v[20], v[24], 3'h0, lvl});
            repeat (3) @(posedge pclk);
            rdc(12'h030, {31'h0, v[20] & (lvl < interrupt_level_mask) & (~v[24] | v[16])});
        end
        for (int i = 0; i < 20; i++)
        begin
            a = (i < 14) ? adrs[i] : $random(seed);
            apb(1'b1, 12'h024, a);
            for (int w = 0; w < 3; w++)
            begin
                apb(1'b1, 12'h028, 32'(w));
                apb(1'b0, 12'h028, 32'h0);
                chk(rd & 32'h170, dec_exp(a, 2'(w)));
            end
        end
        for (int m = 0; m < 4; m++)
        begin
            apb(1'b1, 12'h020, 32'(m));
            chk({31'h0, er}, {31'h0, m != 2});
            apb(1'b0, 12'h020, 32'h0);
            chk(rd & 32'h3, 32'h2);
        end
        apb(1'b1, 12'h038, $random(seed));
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 12'h080, 32'h0);
        chk({31'h0, er}, 32'h1);
        for (int p = 0; p < 8; p++)
        begin
            do_reset(3'(p));
            apb(1'b0, 12'h020, 32'h0);
            v = {24'h0, 3'(p), p == 2 || p > 3, 4'h0};
            chk(rd & 32'hF0, v);
            chk({31'h0, boot_inhibited}, {31'h0, v[4]});
            if (p < 2)
                chk({31'h0, rd[2]}, {31'h0, p == 1});
        end
        final_report();
    end
endmodule : cpu_state_and_boot_mode_tb_top
